// ===== rtl/cfs_page0.sv
/*
  byte fifo and the page-zero top: command control, fifo port and
  main status registers behind the host's byte register port.
  assumes host strobes, modem phase, irq and error inputs come from
  logic on clk_in, so none of them is synchronised here.
*/
// Functional notes
// R1: bit seven reads busy during interface detection
// R2: host writes command code, device starts it
// R3: command field reads back running command
// R4: command register at 01h, bit six zero
// R5: address 02h is the fifo byte port
// R6: fifo port content undefined before writing
// R7: modem phase idle, frame start, frame end
// R8: phase 010 sends fifo bytes out
// R9: modem phase receiver codes 100 to 111
// R10: irq bit shows any enabled pending request
// R11: error bit shows any error flag set
// R12: high alert when free space within threshold
// R13: low alert when fill within threshold
// R14: status at 03h, read only, resets 01h
// R15: fill count follows fifo writes and reads
// R16: requests reach irq only when enabled
// R17: writes to read-only bits are ignored
`timescale 1ns/1ps
`include "cfs_cfg.svh"

// ----------------------------------------
// fifo of flip-flops
// ----------------------------------------
module cfs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `CFS_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // handshakes, honest full and empty
    assign in_ready_out = (count_reg != FULL);
    assign out_valid_out = (count_reg != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;
    assign out_data_out = mem_reg[rd_ptr_reg];
    assign count_out = count_reg;

    // storage, no reset: content undefined until written
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in; // R6
        end
    end

    // pointers wrap at any depth, not only powers of two
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // fill count
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1; // R15
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1; // R15
        end
    end
endmodule

// ----------------------------------------
// page-zero registers
// ----------------------------------------
module cfs_page0 #(
    parameter int DEPTH = `CFS_FIFO_DEPTH,
    parameter int NIRQ = 7,
    parameter int NERR = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire cfs_pkg::cfs_host_req_t host_req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic detect_done_in,
    output logic [5:0] cmd_code_out,
    output logic cmd_start_out,
    input wire logic cmd_done_in,
    input wire logic [2:0] modem_phase_in,
    input wire logic [NIRQ-1:0] irq_request_in,
    input wire logic [NIRQ-1:0] irq_enable_in,
    input wire logic [NERR-1:0] error_flags_in,
    input wire logic [5:0] fifo_threshold_in,
    output logic irq_out,
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CW:0] DEPTH_W = (CW+1)'(DEPTH);

    logic detect_busy_reg;
    logic [5:0] cmd_code_reg;
    logic cmd_start_reg;
    cfs_pkg::cfs_status_t status_reg;
    cfs_pkg::cfs_status_t status_next;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic irq_reg;
    logic [7:0] tx_byte_reg;
    logic tx_valid_reg;
    logic rx_ready_reg;
    logic host_push;
    logic host_pop;
    logic rx_take;
    logic tx_load;
    logic f_in_valid;
    logic f_in_ready;
    logic [7:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [7:0] f_out_data;
    logic [CW-1:0] fill_count;

    // decode of one host access kind at one offset
    function automatic logic hit(input cfs_pkg::cfs_host_req_t r, input logic [5:0] a, input logic w);
        hit = (r.addr == a) && (w ? r.wr : r.rd);
    endfunction

    // ----------------------------------------
    // fifo path: host port has priority over the modem streams
    // ----------------------------------------
    assign host_push = hit(host_req_in, `CFS_ADDR_FIFO, 1'b1); // R5
    assign host_pop = hit(host_req_in, `CFS_ADDR_FIFO, 1'b0); // R5
    assign rx_take = !host_push && rx_valid_in && rx_ready_reg;
    assign f_in_valid = host_push || rx_take;
    assign f_in_data = host_push ? host_req_in.data : rx_byte_in;
    // payload leaves the fifo for the modem only in the transmit-data phase
    assign tx_load = !host_pop && (status_reg.modem_phase == `CFS_PH_TX_PAYLOAD)
                     && (!tx_valid_reg || tx_ready_in); // R8
    assign f_out_ready = host_pop || tx_load;

    cfs_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(f_in_valid),
        .in_ready_out(f_in_ready),
        .in_data_in(f_in_data),
        .out_valid_out(f_out_valid),
        .out_ready_in(f_out_ready),
        .out_data_out(f_out_data),
        .count_out(fill_count)
    );

    // registered ready keeps the port a flop; one slot of margin
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_ready_reg <= 1'b0;
        end else begin
            rx_ready_reg <= ({1'b0, fill_count} < DEPTH_W - 2'd2) && f_in_ready;
        end
    end

    // transmit holding register toward the modem
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_valid_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
        end else if (tx_load && f_out_valid) begin
            tx_valid_reg <= 1'b1; // R8
            tx_byte_reg <= f_out_data;
        end else if (tx_ready_in) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // command control
    // ----------------------------------------
    // detection flag is sticky once done; host writes cannot touch it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            detect_busy_reg <= 1'b1;
        end else if (detect_done_in) begin
            detect_busy_reg <= 1'b0; // R1 R17
        end
    end

    // a new command written in the same cycle as done wins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cmd_code_reg <= `CFS_CMD_IDLE; // R4
            cmd_start_reg <= 1'b0;
        end else begin
            cmd_start_reg <= hit(host_req_in, `CFS_ADDR_CMD, 1'b1); // R2
            if (hit(host_req_in, `CFS_ADDR_CMD, 1'b1)) begin
                cmd_code_reg <= host_req_in.data[5:0]; // R2 R3
            end else if (cmd_done_in) begin
                cmd_code_reg <= `CFS_CMD_IDLE; // R3
            end
        end
    end

    // ----------------------------------------
    // main status, recomputed every cycle
    // ----------------------------------------
    always_comb begin
        status_next.rsvd = 1'b0; // R14
        status_next.modem_phase = modem_phase_in; // R7 R9
        status_next.irq_pending = |(irq_request_in & irq_enable_in); // R10 R16
        status_next.error_summary = |error_flags_in; // R11
        status_next.fifo_high_alert = (DEPTH_W - {1'b0, fill_count}) <= {{(CW-5){1'b0}}, fifo_threshold_in}; // R12
        status_next.fifo_low_alert = {1'b0, fill_count} <= {{(CW-5){1'b0}}, fifo_threshold_in}; // R13
    end

    // status ignores host writes entirely
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_reg <= `CFS_STAT_RESET; // R14
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next; // R17
            irq_reg <= status_next.irq_pending; // R16
        end
    end

    // ----------------------------------------
    // host read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= host_req_in.rd;
            if (host_req_in.rd) begin
                case (host_req_in.addr)
                    `CFS_ADDR_CMD: rd_data_reg <= {detect_busy_reg, 1'b0, cmd_code_reg}; // R1 R3 R4
                    `CFS_ADDR_FIFO: rd_data_reg <= f_out_valid ? f_out_data : 8'h00; // R5
                    `CFS_ADDR_STAT: rd_data_reg <= status_reg; // R14
                    default: rd_data_reg <= 8'h00;
                endcase
            end
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign cmd_code_out = cmd_code_reg;
    assign cmd_start_out = cmd_start_reg;
    assign irq_out = irq_reg;
    assign tx_byte_out = tx_byte_reg;
    assign tx_valid_out = tx_valid_reg;
    assign rx_ready_out = rx_ready_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_busy_sticky: assert property (@(posedge clk_in) disable iff (reset_in) // R1
        !detect_busy_reg |=> !detect_busy_reg) else $error("detect busy came back");
    chk_cmd_start: assert property (@(posedge clk_in) disable iff (reset_in) // R2
        hit(host_req_in, `CFS_ADDR_CMD, 1'b1) |=> cmd_start_out && cmd_code_out == $past(host_req_in.data[5:0]))
        else $error("command write not started");
    chk_cmd_readback: assert property (@(posedge clk_in) disable iff (reset_in) // R3
        hit(host_req_in, `CFS_ADDR_CMD, 1'b0) |=> rd_valid_out && rd_data_out[5:0] == $past(cmd_code_reg))
        else $error("command readback wrong");
    chk_cmd_rsvd: assert property (@(posedge clk_in) disable iff (reset_in) // R4
        hit(host_req_in, `CFS_ADDR_CMD, 1'b0) |=> !rd_data_out[`CFS_CMD_RSVD_BIT]) else $error("bit six set");
    chk_fill_write: assert property (@(posedge clk_in) disable iff (reset_in) // R15
        host_push && f_in_ready && !f_out_ready |=> fill_count == $past(fill_count) + 1'b1)
        else $error("fill count not incremented");
    chk_fill_read: assert property (@(posedge clk_in) disable iff (reset_in) // R15
        host_pop && f_out_valid && !f_in_valid |=> fill_count == $past(fill_count) - 1'b1)
        else $error("fill count not decremented");
    chk_phase_shown: assert property (@(posedge clk_in) disable iff (reset_in) // R7
        1'b1 |=> status_reg.modem_phase == $past(modem_phase_in)) else $error("modem phase stale");
    chk_tx_phase: assert property (@(posedge clk_in) disable iff (reset_in) // R8
        $rose(tx_valid_out) |-> $past(status_reg.modem_phase) == `CFS_PH_TX_PAYLOAD)
        else $error("fifo byte sent outside payload phase");
    chk_irq_gate: assert property (@(posedge clk_in) disable iff (reset_in) // R16
        1'b1 |=> irq_out == |($past(irq_request_in) & $past(irq_enable_in))) else $error("irq gating wrong");
    chk_low_alert: assert property (@(posedge clk_in) disable iff (reset_in) // R13
        1'b1 |=> status_reg.fifo_low_alert == ($past(fill_count) <= $past(fifo_threshold_in)))
        else $error("low alert wrong");
    chk_high_alert: assert property (@(posedge clk_in) disable iff (reset_in) // R12
        1'b1 |=> status_reg.fifo_high_alert == ((DEPTH - int'($past(fill_count))) <= int'($past(fifo_threshold_in))))
        else $error("high alert wrong");
    chk_err_summary: assert property (@(posedge clk_in) disable iff (reset_in) // R11
        1'b1 |=> status_reg.error_summary == ($past(error_flags_in) != '0)) else $error("error summary wrong");
    chk_stat_rsvd: assert property (@(posedge clk_in) disable iff (reset_in) // R14
        hit(host_req_in, `CFS_ADDR_STAT, 1'b0) |=> !rd_data_out[`CFS_STAT_RSVD_BIT]) else $error("status bit seven set");
    chk_busy_wr: assert property (@(posedge clk_in) disable iff (reset_in) // R17
        hit(host_req_in, `CFS_ADDR_CMD, 1'b1) && !detect_done_in |=> detect_busy_reg == $past(detect_busy_reg))
        else $error("write changed busy bit");
endmodule

// ===== rtl/cfs_cfg.svh
/*
  constants of the page-zero command, fifo and status logic.
  assumes inclusion by bare name from the design files.
*/
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CFS_ADDR_CMD 6'h01
`define CFS_ADDR_FIFO 6'h02
`define CFS_ADDR_STAT 6'h03

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CFS_CMD_BUSY_BIT 7
`define CFS_CMD_RSVD_BIT 6
`define CFS_STAT_RSVD_BIT 7
`define CFS_STAT_IRQ_BIT 3
`define CFS_STAT_ERR_BIT 2
`define CFS_STAT_HI_BIT 1
`define CFS_STAT_LO_BIT 0
`define CFS_STAT_RESET 8'h01
`define CFS_CMD_IDLE 6'h00
`define CFS_FIFO_DEPTH 64

// ----------------------------------------
// modem phase codes
// ----------------------------------------
`define CFS_PH_IDLE 3'h0
`define CFS_PH_TX_START 3'h1
`define CFS_PH_TX_PAYLOAD 3'h2
`define CFS_PH_TX_END 3'h3
`define CFS_PH_RX_ENTER 3'h4
`define CFS_PH_RX_GUARD 3'h5
`define CFS_PH_RX_LISTEN 3'h6
`define CFS_PH_RX_DATA 3'h7

`endif

// ===== rtl/cfs_pkg.sv
/*
  types of the page-zero command, fifo and status logic.
  assumes nothing beyond a single clock domain.
*/
package cfs_pkg;

    // ----------------------------------------
    // host register access
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] addr;
        logic wr;
        logic rd;
        logic [7:0] data;
    } cfs_host_req_t;

    // ----------------------------------------
    // main status layout
    // ----------------------------------------
    typedef struct packed {
        logic rsvd;
        logic [2:0] modem_phase;
        logic irq_pending;
        logic error_summary;
        logic fifo_high_alert;
        logic fifo_low_alert;
    } cfs_status_t;

endpackage

// ===== testbench/cfs_host_model.sv
/*
  behavioural host processor on the byte register port.
  assumes the block answers a read strobe exactly one cycle later.
*/
`timescale 1ns/1ps

// ----------------------------------------
// host bus model
// ----------------------------------------
module cfs_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    output cfs_pkg::cfs_host_req_t host_req_out
);
    // bus idle at time zero
    initial begin
        host_req_out = '0;
    end

    // one write strobe; released data flips so stale values never match
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        host_req_out.addr = a;
        host_req_out.data = d;
        host_req_out.wr = 1'b1;
        @(negedge clk_in);
        host_req_out.wr = 1'b0;
        host_req_out.data = ~d;
    endtask

    // one read strobe, answer taken in the following cycle
    task automatic get(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_in);
        host_req_out.addr = a;
        host_req_out.rd = 1'b1;
        @(negedge clk_in);
        host_req_out.rd = 1'b0;
        ok = (rd_valid_in === 1'b1);
        d = rd_data_in;
    endtask
endmodule

// ===== testbench/command_fifo_status_page_test.sv
/*
  self-checking bench of the page-zero registers and byte fifo.
  assumes the host model above and the constants header.
*/
`timescale 1ns/1ps
`include "cfs_cfg.svh"

module command_fifo_status_page_test;
    typedef struct packed {
        logic [2:0] ph;
        logic [6:0] rq;
        logic [6:0] en;
        logic [7:0] er;
        logic [7:0] st;
    } cfs_row_t;
    logic clk_in, reset_in, rd_valid, detect_done, cmd_start, cmd_done, irq;
    logic tx_valid, tx_ready, rx_valid, rx_ready, ok;
    logic [7:0] rd_data, tx_byte, rx_byte, got, err;
    logic [5:0] cmd_code, thr;
    logic [2:0] phase;
    logic [6:0] req, en;
    cfs_pkg::cfs_host_req_t host_req;
    cfs_row_t rows [8];
    int bad_count, tests_run, i, j;

    // ----------------------------------------
    // clock, instances, helpers
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    cfs_host_model u_cfs_host_model (.clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
        .host_req_out(host_req));

    cfs_page0 u_cfs_page0 (.clk_in(clk_in), .reset_in(reset_in), .host_req_in(host_req),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .detect_done_in(detect_done),
        .cmd_code_out(cmd_code), .cmd_start_out(cmd_start), .cmd_done_in(cmd_done),
        .modem_phase_in(phase), .irq_request_in(req), .irq_enable_in(en), .error_flags_in(err),
        .fifo_threshold_in(thr), .irq_out(irq), .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready));

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // status lags its inputs, so settle two cycles before every read
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        repeat (2) @(negedge clk_in);
        u_cfs_host_model.get(a, got, ok);
        check({7'h00, ok}, 8'h01);
        check(got, e);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        bad_count = 0;
        tests_run = 0;
        reset_in = 1'b1;
        {detect_done, cmd_done, tx_ready, rx_valid} = 4'h0;
        {phase, req, en, err, thr, rx_byte} = '0;
        // phase, request, enable, error flags, expected status (count 0, threshold 0)
        rows[0] = {3'h0, 7'h00, 7'h00, 8'h00, 8'h01};
        rows[1] = {3'h1, 7'h7f, 7'h00, 8'h00, 8'h11};
        rows[2] = {3'h2, 7'h01, 7'h01, 8'h00, 8'h29};
        rows[3] = {3'h3, 7'h40, 7'h20, 8'h00, 8'h31};
        rows[4] = {3'h4, 7'h00, 7'h7f, 8'h80, 8'h45};
        rows[5] = {3'h5, 7'h04, 7'h04, 8'h01, 8'h5d};
        rows[6] = {3'h6, 7'h00, 7'h00, 8'h00, 8'h61};
        rows[7] = {3'h7, 7'h00, 7'h00, 8'h01, 8'h75};
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        // table of modem phases, requests and errors; fifo is empty so no tx load
        for (i = 0; i < 8; i++) begin
            @(negedge clk_in);
            {phase, req, en, err} = {rows[i].ph, rows[i].rq, rows[i].en, rows[i].er};
            repeat (3) @(negedge clk_in);
            check({7'h00, irq}, {7'h00, rows[i].st[3]});
            rd_chk(`CFS_ADDR_STAT, rows[i].st);
        end
        {phase, req, en, err} = '0;
        // busy until detection ends; bit six never set; code reads back
        rd_chk(`CFS_ADDR_CMD, 8'h80);
        u_cfs_host_model.put(`CFS_ADDR_CMD, 8'hff);
        check({2'h0, cmd_code}, 8'h3f);
        check({7'h00, cmd_start}, 8'h01);
        rd_chk(`CFS_ADDR_CMD, 8'hbf);
        check({7'h00, cmd_start}, 8'h00);
        @(negedge clk_in);
        cmd_done = 1'b1;
        @(negedge clk_in);
        cmd_done = 1'b0;
        rd_chk(`CFS_ADDR_CMD, 8'h80);
        detect_done = 1'b1;
        @(negedge clk_in);
        detect_done = 1'b0;
        rd_chk(`CFS_ADDR_CMD, 8'h00);
        u_cfs_host_model.put(`CFS_ADDR_CMD, 8'hc0);
        rd_chk(`CFS_ADDR_CMD, 8'h00);
        u_cfs_host_model.put(`CFS_ADDR_STAT, 8'hfe);
        rd_chk(`CFS_ADDR_STAT, 8'h01);
        // fill past full around both alert boundaries, threshold 4
        thr = 6'h04;
        for (i = 0; i < 65; i++) begin
            u_cfs_host_model.put(`CFS_ADDR_FIFO, 8'(i + 16));
            if (i == 3 || i == 59) rd_chk(`CFS_ADDR_STAT, 8'h01 << (i / 59));
            if (i == 4 || i == 58) rd_chk(`CFS_ADDR_STAT, 8'h00);
        end
        // drain in order; the dropped byte never appears, empty reads give zero
        for (i = 0; i < 65; i++) begin
            rd_chk(`CFS_ADDR_FIFO, (i < 64) ? 8'(i + 16) : 8'h00);
        end
        // transmit stream: stalled far side holds the first byte
        for (i = 0; i < 3; i++) begin
            u_cfs_host_model.put(`CFS_ADDR_FIFO, 8'(i + 8'ha0));
        end
        phase = `CFS_PH_TX_PAYLOAD;
        repeat (5) @(negedge clk_in);
        check({7'h00, tx_valid}, 8'h01);
        check(tx_byte, 8'ha0);
        tx_ready = 1'b1;
        j = 1;
        for (i = 0; i < 20; i++) begin
            @(negedge clk_in);
            if (tx_valid === 1'b1 && j < 3) begin
                check(tx_byte, 8'(j + 8'ha0));
                j++;
            end
        end
        check(8'(j), 8'h03);
        {phase, tx_ready} = '0;
        // receive stream: one byte enters and the host reads it out
        @(negedge clk_in);
        check({7'h00, rx_ready}, 8'h01);
        rx_byte = 8'hc5;
        rx_valid = 1'b1;
        @(negedge clk_in);
        rx_valid = 1'b0;
        rd_chk(`CFS_ADDR_FIFO, 8'hc5);
        rd_chk(`CFS_ADDR_FIFO, 8'h00);
        // second reset in mid-run restores reset values
        u_cfs_host_model.put(`CFS_ADDR_CMD, 8'h2a);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        check({2'h0, cmd_code}, 8'h00);
        reset_in = 1'b0;
        rd_chk(`CFS_ADDR_CMD, 8'h80);
        rd_chk(`CFS_ADDR_STAT, 8'h01);
        tally_and_finish();
    end
endmodule
